// ==== design/tx_pause_params.svh ====
// offsets, reset values and timing figures of the transmit pause block
`ifndef TX_PAUSE_PARAMS_SVH
`define TX_PAUSE_PARAMS_SVH
// ============================================================
// register word indices (byte address is four times the index)
`define IDX_REVISION 12'h600
`define IDX_SCRATCH 12'h601
`define IDX_LABEL_0 12'h602
`define IDX_LABEL_1 12'h603
`define IDX_LABEL_2 12'h604
`define IDX_SEND_EN 12'h605
`define IDX_REQUEST 12'h606
`define IDX_REPEAT_EN 12'h607
`define IDX_REPEAT_IVL 12'h608
`define IDX_PAUSE_TIME 12'h609
`define IDX_QUEUE_SEL 12'h60a
// ============================================================
// reset values
`define RST_SCRATCH 32'h0000_0000
`define RST_QUANTA 16'hffff
`define RST_QUANTA_CNT 16'h0000
// arbitrary identity values
`define REVISION_VALUE 32'h0000_0001
`define LABEL_0_VALUE 32'h5446_4331
`define LABEL_1_VALUE 32'h5846_4332
`define LABEL_2_VALUE 32'h5046_4333
// ============================================================
// timing: one quantum is 512 bit times; clock cycles per quantum
`define QUANTUM_BITS 512
`define QUANTUM_CYCLES 1
`endif

// ==== design/tx_pause_pkg.sv ====
// types shared by the transmit pause block
package tx_pause_pkg;
  // ============================================================
  // register bus handshake state; code 1 keeps waitrequest high
  typedef enum logic [0:0] {
    BUS_WAIT = 1'b1,
    BUS_DONE = 1'b0
  } bus_state_e;
endpackage : tx_pause_pkg

// ==== design/tx_pause_frame_control.sv ====
// transmit pause frame control: xoff/xon insertion, repeat timers, register window
`timescale 1ns/1ps
`include "tx_pause_params.svh"

module tx_pause_frame_control import tx_pause_pkg::*; #(
  parameter int N_QUEUES = 1,
  parameter int QW = (N_QUEUES > 1) ? $clog2(N_QUEUES) : 1,
  parameter int QUANTUM_CYCLES = `QUANTUM_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [13:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [N_QUEUES-1:0] i_pause_request,
  input wire logic i_pause_ready,
  output logic o_pause_valid,
  output logic o_pause_xoff,
  output logic [QW-1:0] o_pause_queue,
  output logic [15:0] o_pause_time
);

  // ============================================================
  // register word decode
  function automatic logic hit(input logic [13:0] addr, input logic [11:0] idx);
    hit = (addr[13:2] == idx);
  endfunction : hit

  bus_state_e bus_q, bus_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] scratch_q;
  logic [N_QUEUES-1:0] en_q, req_q, rep_q, off_q;
  logic [QW-1:0] qsel_q;
  logic [15:0] ivl_q [N_QUEUES];
  logic [15:0] ptime_q [N_QUEUES];
  logic [15:0] tmr_q [N_QUEUES];
  logic [15:0] qcnt_q;
  logic tick;
  logic valid_q, xoff_q;
  logic [QW-1:0] queue_q;
  logic [15:0] time_q;

  wire logic bus_req = i_avs_read | i_avs_write;
  wire logic bus_first = bus_req & (bus_q == BUS_WAIT);
  wire logic wr_acc = i_avs_write & (bus_q == BUS_DONE);
  wire logic qsel_ok = (32'(qsel_q) < N_QUEUES);
  wire logic [31:0] nmask = 32'((33'h1 << N_QUEUES) - 33'h1);

  // ============================================================
  // effective request and per-queue wants
  wire logic [N_QUEUES-1:0] active = req_q | i_pause_request;
  logic [N_QUEUES-1:0] want_off, want_on, want_rep;
  always_comb begin
    for (int i = 0; i < N_QUEUES; i++) begin
      want_off[i] = en_q[i] & active[i] & ~off_q[i];
      want_on[i] = en_q[i] & ~active[i] & off_q[i];
      want_rep[i] = en_q[i] & active[i] & off_q[i] & rep_q[i] & (tmr_q[i] == 16'h0);
    end
  end

  // lowest queue number with something to send wins
  logic sel_any, sel_xoff;
  logic [QW-1:0] sel_idx;
  always_comb begin
    sel_any = 1'b0;
    sel_xoff = 1'b0;
    sel_idx = '0;
    for (int i = N_QUEUES - 1; i >= 0; i--) begin
      if (want_off[i] | want_on[i] | want_rep[i]) begin
        sel_any = 1'b1;
        sel_xoff = ~want_on[i];
        sel_idx = QW'(i);
      end
    end
  end
  wire logic issue = sel_any & ~valid_q;

  // ============================================================
  // quantum tick divider
  wire logic [15:0] qcnt_last = 16'(QUANTUM_CYCLES - 1);
  assign tick = (qcnt_q == qcnt_last);
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) qcnt_q <= `RST_QUANTA_CNT;
    else qcnt_q <= tick ? `RST_QUANTA_CNT : qcnt_q + 16'h1;
  end

  // ============================================================
  // read data mux
  always_comb begin
    rdata_d = 32'h0;
    if (hit(i_avs_address, `IDX_REVISION)) rdata_d = `REVISION_VALUE;
    if (hit(i_avs_address, `IDX_SCRATCH)) rdata_d = scratch_q;
    if (hit(i_avs_address, `IDX_LABEL_0)) rdata_d = `LABEL_0_VALUE;
    if (hit(i_avs_address, `IDX_LABEL_1)) rdata_d = `LABEL_1_VALUE;
    if (hit(i_avs_address, `IDX_LABEL_2)) rdata_d = `LABEL_2_VALUE;
    if (hit(i_avs_address, `IDX_SEND_EN)) rdata_d = 32'(en_q);
    if (hit(i_avs_address, `IDX_REQUEST)) rdata_d = 32'(req_q);
    if (hit(i_avs_address, `IDX_REPEAT_EN)) rdata_d = 32'(rep_q);
    if (hit(i_avs_address, `IDX_QUEUE_SEL)) rdata_d = 32'(qsel_q);
    if (hit(i_avs_address, `IDX_REPEAT_IVL) && qsel_ok) rdata_d = 32'(ivl_q[qsel_q]);
    if (hit(i_avs_address, `IDX_PAUSE_TIME) && qsel_ok) rdata_d = 32'(ptime_q[qsel_q]);
  end

  // bus handshake: one wait cycle, then answer
  assign bus_d = bus_first ? BUS_DONE : BUS_WAIT;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bus_q <= BUS_WAIT;
      rdata_q <= 32'h0;
    end else begin
      bus_q <= bus_d;
      if (bus_first) rdata_q <= rdata_d;
    end
  end
  assign o_avs_waitrequest = bus_q[0];
  assign o_avs_readdata = rdata_q;

  // ============================================================
  // flat control registers
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scratch_q <= `RST_SCRATCH;
      en_q <= '1;
      req_q <= '0;
      rep_q <= '1;
      qsel_q <= '0;
    end else if (wr_acc) begin
      if (hit(i_avs_address, `IDX_SCRATCH)) scratch_q <= i_avs_writedata;
      if (hit(i_avs_address, `IDX_SEND_EN)) en_q <= N_QUEUES'(i_avs_writedata & nmask);
      if (hit(i_avs_address, `IDX_REQUEST)) req_q <= N_QUEUES'(i_avs_writedata & nmask);
      if (hit(i_avs_address, `IDX_REPEAT_EN)) rep_q <= N_QUEUES'(i_avs_writedata & nmask);
      if (hit(i_avs_address, `IDX_QUEUE_SEL)) qsel_q <= QW'(i_avs_writedata);
    end
  end

  // per-queue tables, repeat timers and sent-xoff state
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_QUEUES; i++) begin
        ivl_q[i] <= `RST_QUANTA;
        ptime_q[i] <= `RST_QUANTA;
        tmr_q[i] <= `RST_QUANTA_CNT;
      end
      off_q <= '0;
    end else begin
      for (int i = 0; i < N_QUEUES; i++) begin
        if (issue && sel_idx == QW'(i)) tmr_q[i] <= ivl_q[i];
        else if (tick && tmr_q[i] != 16'h0) tmr_q[i] <= tmr_q[i] - 16'h1;
        if (wr_acc && qsel_q == QW'(i)) begin
          if (hit(i_avs_address, `IDX_REPEAT_IVL)) ivl_q[i] <= i_avs_writedata[15:0];
          if (hit(i_avs_address, `IDX_PAUSE_TIME)) ptime_q[i] <= i_avs_writedata[15:0];
        end
      end
      if (issue) off_q[sel_idx] <= sel_xoff;
    end
  end

  // ============================================================
  // frame request to the transmit datapath, held until taken
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_q <= 1'b0;
      xoff_q <= 1'b0;
      queue_q <= '0;
      time_q <= 16'h0;
    end else if (issue) begin
      valid_q <= 1'b1;
      xoff_q <= sel_xoff;
      queue_q <= sel_idx;
      time_q <= sel_xoff ? ptime_q[sel_idx] : 16'h0;
    end else if (i_pause_ready) begin
      valid_q <= 1'b0;
    end
  end
  assign o_pause_valid = valid_q;
  assign o_pause_xoff = xoff_q;
  assign o_pause_queue = queue_q;
  assign o_pause_time = time_q;

  // ============================================================
  // checks
  sequence s_bus_first;
    bus_req && o_avs_waitrequest;
  endsequence
  sequence s_bus_answer;
    !o_avs_waitrequest;
  endsequence

  a_bus_one_wait: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_bus_first |=> s_bus_answer ##1 o_avs_waitrequest)
    else $error("bus answer not after exactly one wait cycle");
  a_revision_read: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_bus_first and (i_avs_read && hit(i_avs_address, `IDX_REVISION))
    |=> o_avs_readdata == `REVISION_VALUE)
    else $error("revision read returned wrong value");
  a_scratch_keeps: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_acc && hit(i_avs_address, `IDX_SCRATCH)) |=> scratch_q == $past(i_avs_writedata))
    else $error("scratch write not stored");
  a_disabled_quiet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!en_q[0] && !valid_q) |=> !(valid_q && o_pause_queue == '0))
    else $error("frame issued for a disabled queue");
  a_xoff_on_raise: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!valid_q && en_q[0] && active[0] && !off_q[0])
    |=> valid_q && o_pause_xoff && o_pause_queue == '0)
    else $error("xoff not issued after request");
  a_xon_on_drop: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (!valid_q && en_q[0] && !active[0] && off_q[0])
    |=> valid_q && !o_pause_xoff && o_pause_queue == '0)
    else $error("xon not issued after request dropped");
  a_repeat_spacing: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ($rose(valid_q) && o_pause_xoff && o_pause_queue == '0 && $past(off_q[0]))
    |-> $past(tmr_q[0]) == 16'h0 && $past(rep_q[0]))
    else $error("xoff repeated before interval ran out");
  a_pause_time: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (issue && sel_xoff) |=> o_pause_time == $past(ptime_q[sel_idx]))
    else $error("xoff carries wrong pause time");
  a_timer_load: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (issue && sel_idx == '0) |=> tmr_q[0] == $past(ivl_q[0]))
    else $error("repeat timer not loaded at issue");
  a_hold_frame: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (valid_q && !i_pause_ready) |=> valid_q && $stable(o_pause_queue) && $stable(o_pause_xoff))
    else $error("frame request changed before taken");

  // ============================================================
  // frame handshake checks
  sequence s_frame_taken;
    valid_q && i_pause_ready;
  endsequence
  sequence s_frame_idle;
    !valid_q && !sel_any;
  endsequence

  // a taken frame always leaves one idle cycle
  a_frame_drops: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_frame_taken |=> !valid_q)
    else $error("frame request stayed up after taken");
  // nothing wanted, nothing issued
  a_no_spurious: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_frame_idle |=> !valid_q)
    else $error("frame issued with no queue wanting one");
  // xon frames carry a zero pause time
  a_xon_no_time: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (valid_q && !o_pause_xoff) |-> o_pause_time == 16'h0)
    else $error("xon frame carries a pause time");
  // queue number stays inside the configured queue count
  a_queue_range: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    valid_q |-> 32'(o_pause_queue) < N_QUEUES)
    else $error("frame names a queue that does not exist");

  // ============================================================
  // register window checks
  // scratch read returns the stored word
  a_scratch_read: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_bus_first and (i_avs_read && hit(i_avs_address, `IDX_SCRATCH))
    |=> o_avs_readdata == $past(scratch_q))
    else $error("scratch read returned wrong value");
  // first label word read
  a_label_read: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_bus_first and (i_avs_read && hit(i_avs_address, `IDX_LABEL_0))
    |=> o_avs_readdata == `LABEL_0_VALUE)
    else $error("label read returned wrong value");
  // send enable write lands masked to the queue count
  a_enable_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_acc && hit(i_avs_address, `IDX_SEND_EN))
    |=> en_q == $past(N_QUEUES'(i_avs_writedata & nmask)))
    else $error("send enable write not stored");
  // request write lands masked to the queue count
  a_request_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_acc && hit(i_avs_address, `IDX_REQUEST))
    |=> req_q == $past(N_QUEUES'(i_avs_writedata & nmask)))
    else $error("request write not stored");
  // repeat enable write lands masked to the queue count
  a_repeat_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_acc && hit(i_avs_address, `IDX_REPEAT_EN))
    |=> rep_q == $past(N_QUEUES'(i_avs_writedata & nmask)))
    else $error("repeat enable write not stored");
  // pause time write reaches the selected table entry
  a_table_write: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (wr_acc && hit(i_avs_address, `IDX_PAUSE_TIME) && qsel_ok)
    |=> ptime_q[$past(qsel_q)] == $past(i_avs_writedata[15:0]))
    else $error("pause time table write lost");

  // ============================================================
  // timer checks
  // divider restarts after each tick
  a_tick_wrap: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    tick |=> qcnt_q == `RST_QUANTA_CNT)
    else $error("quantum divider did not wrap");
  // repeat timer of queue zero counts down one per quantum
  a_timer_count: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (tick && tmr_q[0] != 16'h0 && !(issue && sel_idx == '0))
    |=> tmr_q[0] == $past(tmr_q[0]) - 16'h1)
    else $error("repeat timer did not count down");

endmodule : tx_pause_frame_control

// ==== test/pause_sink.sv ====
// transmit datapath model that takes pause frames after a set delay
`timescale 1ns/1ps
module pause_sink (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [3:0] i_delay,
  output logic o_ready
);
  logic [3:0] wait_q;
  // ready after i_delay cycles of valid, held one cycle only
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q <= 4'h0;
      o_ready <= 1'b0;
    end else begin
      o_ready <= i_valid && !o_ready && (wait_q >= i_delay);
      wait_q <= (i_valid && !o_ready) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : pause_sink

// ==== test/test_tx_pause_frame_control.sv ====
// self-checking bench for the transmit pause block, two queues
`timescale 1ns/1ps
`include "tx_pause_params.svh"
module test_tx_pause_frame_control;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] seed = 32'h2ec72977;
  logic [1:0] req = 2'h0;
  logic [3:0] dly = 4'h0;
  logic [31:0] rdat, wd;
  logic wreq, vld, xoff, rdy, qn;
  logic [15:0] ptim, t0, t1;
  logic [31:0] rexp[$];
  logic [17:0] fexp[$];
  int n_fail = 0;
  int num_checks = 0;
  tx_pause_frame_control #(.N_QUEUES(2)) dut (.i_core_clk(clk), .i_nrst(nrst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_pause_request(req),
    .i_pause_ready(rdy), .o_pause_valid(vld), .o_pause_xoff(xoff), .o_pause_queue(qn),
    .o_pause_time(ptim));
  pause_sink sink (.i_core_clk(clk), .i_nrst(nrst), .i_valid(vld), .i_delay(dly),
    .o_ready(rdy));
  // clock
  initial forever #50 clk = ~clk;
  // ============================================================
  // bus cycles and comparisons
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int g;
    g = 0;
    @(posedge clk);
    adr <= {idx, 2'b00};
    wdat <= d;
    rd <= !w;
    wr <= w;
    // hold the request until the rising edge that samples waitrequest low
    do begin
      @(posedge clk);
      g++;
    end while (wreq !== 1'b0 && g < 50);
    if (g >= 50) n_fail++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e);
    rexp.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask : rd_chk
  task automatic chk_word(input logic [31:0] e);
    num_checks++;
    if (rdat !== e) begin
      n_fail++;
      $display("[ERR] %0t read %h expected %h", $time, rdat, e);
    end
  endtask : chk_word
  task automatic chk_frame(input logic [17:0] e);
    num_checks++;
    if ({xoff, qn, ptim} !== e) begin
      n_fail++;
      $display("[ERR] %0t frame %h expected %h", $time, {xoff, qn, ptim}, e);
    end
  endtask : chk_frame
  // wait until all noted frames went out, then idle to catch extras
  task automatic drain;
    int g;
    g = 0;
    while (fexp.size() != 0 && g < 400) begin
      @(posedge clk);
      g++;
    end
    if (fexp.size() != 0) n_fail++;
    repeat (12) @(posedge clk);
  endtask : drain
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // monitor: oldest note against each result seen
  always @(negedge clk) begin
    if (rd && wreq === 1'b0) chk_word(rexp.pop_front());
    if (vld === 1'b1 && rdy === 1'b1) begin
      if (fexp.size() == 0) begin
        n_fail++;
        $display("[ERR] %0t frame with nothing expected", $time);
      end else begin
        chk_frame(fexp.pop_front());
      end
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
  // ============================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(`IDX_REVISION, `REVISION_VALUE);
    rd_chk(`IDX_SCRATCH, 32'h0);
    rd_chk(`IDX_LABEL_0, `LABEL_0_VALUE);
    rd_chk(`IDX_LABEL_1, `LABEL_1_VALUE);
    rd_chk(`IDX_LABEL_2, `LABEL_2_VALUE);
    rd_chk(`IDX_SEND_EN, 32'h3);
    rd_chk(`IDX_REQUEST, 32'h0);
    rd_chk(`IDX_REPEAT_EN, 32'h3);
    rd_chk(`IDX_REPEAT_IVL, 32'hffff);
    rd_chk(`IDX_PAUSE_TIME, 32'hffff);
    rd_chk(12'h7ff, 32'h0);
    wd = $random(seed);
    bus(1'b1, `IDX_SCRATCH, wd);
    bus(1'b1, `IDX_REVISION, ~wd);
    rd_chk(`IDX_SCRATCH, wd);
    rd_chk(`IDX_REVISION, `REVISION_VALUE);
    // per-queue pause times through the select window
    t0 = $random(seed);
    t1 = $random(seed);
    bus(1'b1, `IDX_QUEUE_SEL, 32'h0);
    bus(1'b1, `IDX_PAUSE_TIME, {16'h0, t0});
    bus(1'b1, `IDX_QUEUE_SEL, 32'h1);
    bus(1'b1, `IDX_PAUSE_TIME, {16'h0, t1});
    bus(1'b1, `IDX_REPEAT_IVL, 32'h1e);
    rd_chk(`IDX_PAUSE_TIME, {16'h0, t1});
    bus(1'b1, `IDX_QUEUE_SEL, 32'h0);
    rd_chk(`IDX_PAUSE_TIME, {16'h0, t0});
    rd_chk(`IDX_REPEAT_IVL, 32'hffff);
    // input path, slow taker
    dly <= 4'h3;
    fexp.push_back({2'b10, t0});
    req[0] <= 1'b1;
    drain();
    fexp.push_back(18'h0);
    req[0] <= 1'b0;
    drain();
    // register path, prompt taker
    dly <= 4'h0;
    fexp.push_back({2'b11, t1});
    bus(1'b1, `IDX_REQUEST, 32'h2);
    drain();
    rd_chk(`IDX_REQUEST, 32'h2);
    fexp.push_back({2'b01, 16'h0});
    bus(1'b1, `IDX_REQUEST, 32'h0);
    drain();
    // disabled queue sends nothing
    bus(1'b1, `IDX_SEND_EN, 32'h2);
    req[0] <= 1'b1;
    drain();
    req[0] <= 1'b0;
    drain();
    bus(1'b1, `IDX_SEND_EN, 32'h3);
    // repeats on queue 0 only, lowest queue first
    bus(1'b1, `IDX_REPEAT_IVL, 32'h1e);
    bus(1'b1, `IDX_REPEAT_EN, 32'h1);
    rd_chk(`IDX_REPEAT_EN, 32'h1);
    fexp.push_back({2'b10, t0});
    fexp.push_back({2'b11, t1});
    fexp.push_back({2'b10, t0});
    fexp.push_back({2'b10, t0});
    req <= 2'b11;
    drain();
    fexp.push_back(18'h0);
    fexp.push_back({2'b01, 16'h0});
    req <= 2'b00;
    drain();
    bus(1'b1, `IDX_REPEAT_EN, 32'h3);
    rd_chk(`IDX_REPEAT_EN, 32'h3);
    results();
  end
endmodule : test_tx_pause_frame_control
